/* tap_decode.sv */
// Test-port instruction register, decoder and data registers of the burst memory
// Summary of operation
// - Reserved codes 011 and 110 act exactly as bypass, one-bit path.
// - Code 100 samples pin levels on Capture-DR, then shifts boundary register.
// - Code 111 routes serial path through the one-bit bypass register.
// - Codes are three bits, most significant bit leftmost, on both sides.
// - Default instruction loads at power-up and on test-logic-reset.
// - Code 001 default; captures 32-bit identity, shifts it out LSB first.
// - Code 000 shifts boundary register and drives its contents onto outputs.
// - Code 010 floats all outputs, captures pins, shifts boundary register.
// - Capture-IR loads 01 low bits; new code acts only at Update-IR.
`timescale 1ns/1ns
module tap_decode
	import tap_decode_pkg::*;
#(
	parameter int BSR_W = BSR_W_DEFAULT,
	parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic tck_i,
	input wire tap_state_t tap_i,
	input wire logic tdi_i,
	input wire logic [BSR_W-1:0] pins_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic [BSR_W-1:0] bsr_drive_o,
	output logic extest_o,
	output logic highz_o
);

	////////////////////////////////////////////////////////////////////////////
	// Decode of one instruction code
	function automatic ir_dec_t decode(input logic [IR_W-1:0] code);
		ir_dec_t d;
		d = '0;
		unique case (code)
			OP_EXTEST: begin
				d.is_bsr = 1'b1;
				d.capture_pins = 1'b1;
				d.extest = 1'b1;
			end
			OP_IDCODE: begin
				d.is_id = 1'b1;
			end
			OP_SAMPLE_Z: begin
				d.is_bsr = 1'b1;
				d.capture_pins = 1'b1;
				d.highz = 1'b1;
			end
			OP_SAMPLE: begin
				d.is_bsr = 1'b1;
				d.capture_pins = 1'b1;
			end
			// Reserved, private and bypass codes all fall to bypass
			OP_RESERVED_A, OP_PRIVATE, OP_RESERVED_B, OP_BYPASS: begin
				d = '0;
			end
		endcase
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Reset and pin crossings into the test-clock domain
	logic tck_rstn;
	logic [BSR_W-1:0] pins_s;

	// Power-up reset reaches tck logic through its own synchroniser
	sync2 #(.W(1)) u_rst_sync (
		.clock_i(tck_i),
		.rstn_i(1'b1),
		.d_i(rstn_i),
		.q_o(tck_rstn)
	);

	// Pin levels move with the memory clock; sampling mid-transition is only harmless
	sync2 #(.W(BSR_W)) u_pin_sync (
		.clock_i(tck_i),
		.rstn_i(tck_rstn),
		.d_i(pins_i),
		.q_o(pins_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Instruction register
	logic [IR_W-1:0] ir_shift_r;
	logic [IR_W-1:0] ir_shift_nxt;
	logic [IR_W-1:0] ir_r;
	logic [IR_W-1:0] ir_nxt;
	logic ir_reset;
	ir_dec_t dec;

	assign ir_reset = !tck_rstn || tap_i.test_reset;
	assign dec = decode(ir_r);

	always_comb begin
		ir_shift_nxt = ir_shift_r;
		ir_nxt = ir_r;
		if (ir_reset) begin
			ir_shift_nxt = IR_RESET;
			ir_nxt = IR_RESET;
		end else begin
			if (tap_i.capture_ir) begin
				ir_shift_nxt = IR_CAPTURE_FULL;
			end
			if (tap_i.shift_ir) begin
				ir_shift_nxt = {tdi_i, ir_shift_r[IR_W-1:1]};
			end
			if (tap_i.update_ir) begin
				ir_nxt = ir_shift_r;
			end
		end
	end

	always_ff @(posedge tck_i) begin
		ir_shift_r <= ir_shift_nxt;
		ir_r <= ir_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Data registers: bypass, identity and boundary scan
	logic bypass_r;
	logic bypass_nxt;
	logic [ID_W-1:0] id_r;
	logic [ID_W-1:0] id_nxt;
	logic [BSR_W-1:0] bsr_r;
	logic [BSR_W-1:0] bsr_nxt;
	logic [BSR_W-1:0] drive_r;
	logic [BSR_W-1:0] drive_nxt;
	dr_sel_t sel;

	// Selected data register; anything not boundary or identity is bypass
	always_comb begin
		if (dec.is_id) begin
			sel = SEL_ID;
		end else if (dec.is_bsr) begin
			sel = SEL_BSR;
		end else begin
			sel = SEL_BYPASS;
		end
	end

	always_comb begin
		bypass_nxt = bypass_r;
		id_nxt = id_r;
		bsr_nxt = bsr_r;
		drive_nxt = drive_r;
		if (ir_reset) begin
			bypass_nxt = 1'b0;
			id_nxt = '0;
			bsr_nxt = '0;
			drive_nxt = '0;
		end else begin
			if (tap_i.capture_dr) begin
				unique case (sel)
					SEL_BYPASS: bypass_nxt = 1'b0;
					SEL_ID: id_nxt = ID_VALUE;
					SEL_BSR: bsr_nxt = dec.capture_pins ? pins_s : bsr_r;
				endcase
			end
			if (tap_i.shift_dr) begin
				unique case (sel)
					SEL_BYPASS: bypass_nxt = tdi_i;
					SEL_ID: id_nxt = {tdi_i, id_r[ID_W-1:1]};
					SEL_BSR: bsr_nxt = {tdi_i, bsr_r[BSR_W-1:1]};
				endcase
			end
			// Preload lands in the drive stage for any boundary instruction
			if (tap_i.update_dr && sel == SEL_BSR) begin
				drive_nxt = bsr_r;
			end
		end
	end

	always_ff @(posedge tck_i) begin
		bypass_r <= bypass_nxt;
		id_r <= id_nxt;
		bsr_r <= bsr_nxt;
		drive_r <= drive_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial output, registered so the pin changes once per tck
	logic tdo_nxt;
	logic tdo_oe_nxt;

	always_comb begin
		tdo_nxt = 1'b0;
		tdo_oe_nxt = 1'b0;
		if (!ir_reset && tap_i.shift_ir) begin
			tdo_nxt = ir_shift_r[0];
			tdo_oe_nxt = 1'b1;
		end else if (!ir_reset && tap_i.shift_dr) begin
			tdo_oe_nxt = 1'b1;
			unique case (sel)
				SEL_BYPASS: tdo_nxt = bypass_r;
				SEL_ID: tdo_nxt = id_r[0];
				SEL_BSR: tdo_nxt = bsr_r[0];
			endcase
		end
	end

	always_ff @(posedge tck_i) begin
		tdo_o <= tdo_nxt;
		tdo_oe_o <= tdo_oe_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin control levels in tck domain, from the instruction about to stand
	logic extest_tck_r;
	logic highz_tck_r;
	ir_dec_t dec_nxt;

	assign dec_nxt = decode(ir_nxt);

	always_ff @(posedge tck_i) begin
		extest_tck_r <= dec_nxt.extest;
		highz_tck_r <= dec_nxt.highz;
		bsr_drive_o <= drive_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Levels cross into the memory clock domain
	logic [1:0] ctl_s;
	logic extest_nxt;
	logic highz_nxt;

	sync2 #(.W(2)) u_ctl_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.d_i({extest_tck_r, highz_tck_r}),
		.q_o(ctl_s)
	);

	always_comb begin
		extest_nxt = rstn_i ? ctl_s[1] : 1'b0;
		highz_nxt = rstn_i ? ctl_s[0] : 1'b0;
	end

	always_ff @(posedge clock_i) begin
		extest_o <= extest_nxt;
		highz_o <= highz_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	reserved_bypass_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.shift_dr && !tap_i.test_reset && !tap_i.shift_ir &&
			(ir_r == OP_RESERVED_A || ir_r == OP_RESERVED_B))
		|=> (tdo_o == $past(bypass_r) && tdo_oe_o))
		else $error("reserved code did not shift through bypass");

	sample_capture_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.capture_dr && !tap_i.shift_dr && !tap_i.test_reset && ir_r == OP_SAMPLE)
		|=> bsr_r == $past(pins_s))
		else $error("sample did not capture pin levels");

	bypass_capture_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.capture_dr && !tap_i.shift_dr && !tap_i.test_reset && ir_r == OP_BYPASS)
		|=> !bypass_r)
		else $error("bypass capture not zero");

	ir_order_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.shift_ir && !tap_i.test_reset) ##1 (tap_i.shift_ir && !tap_i.test_reset)
		|=> ir_shift_r[IR_W-2] == $past(tdi_i, 2))
		else $error("instruction bits out of order");

	default_load_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		tap_i.test_reset |=> (ir_r == OP_IDCODE && !extest_tck_r && !highz_tck_r))
		else $error("default instruction not loaded");

	private_bypass_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.shift_dr && !tap_i.test_reset && !tap_i.shift_ir && ir_r == OP_PRIVATE)
		|=> tdo_o == $past(bypass_r))
		else $error("private code not treated as bypass");

	id_capture_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.capture_dr && !tap_i.shift_dr && !tap_i.test_reset && ir_r == OP_IDCODE)
		##1 (tap_i.shift_dr && !tap_i.test_reset && !tap_i.shift_ir && ir_r == OP_IDCODE)
		|=> tdo_o == ID_VALUE[0])
		else $error("identity LSB not first out");

	extest_drive_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.update_ir && !tap_i.test_reset && ir_shift_r == OP_EXTEST)
		|=> (extest_tck_r && !highz_tck_r))
		else $error("extest did not enable boundary drive");

	highz_force_a: assert property (
		@(posedge clock_i) disable iff (!rstn_i)
		$rose(highz_tck_r) |-> ##[2:8] highz_o)
		else $error("outputs not floated for sample-z");

	capture_ir_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(tap_i.capture_ir && !tap_i.shift_ir && !tap_i.test_reset)
		|=> ir_shift_r[1:0] == IR_CAPTURE)
		else $error("capture-ir pattern wrong");

	update_only_a: assert property (
		@(posedge tck_i) disable iff (!tck_rstn)
		(!tap_i.update_ir && !tap_i.test_reset) |=> $stable(ir_r))
		else $error("instruction changed outside update-ir");

endmodule

/* tap_decode_pkg.sv */
// Package and two-flop synchroniser for the test-port instruction decoder
package tap_decode_pkg;
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] OP_SAMPLE_Z = 3'h2;
	localparam logic [IR_W-1:0] OP_RESERVED_A = 3'h3;
	localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
	localparam logic [IR_W-1:0] OP_PRIVATE = 3'h5;
	localparam logic [IR_W-1:0] OP_RESERVED_B = 3'h6;
	localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
	// Default instruction after power-up and test-logic-reset
	localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;
	// Fixed pattern in the two low bits on Capture-IR
	localparam logic [1:0] IR_CAPTURE = 2'h1;
	localparam logic [IR_W-1:0] IR_CAPTURE_FULL = {1'b0, IR_CAPTURE};
	// Arbitrary identification value, not that of any real part
	localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_0001;
	localparam int BSR_W_DEFAULT = 8;

	typedef enum {SEL_BYPASS, SEL_BSR, SEL_ID} dr_sel_t;

	// Strobes from the test-port state machine on tck; shift strobes hold for one cycle per bit
	typedef struct packed {
		logic test_reset;
		logic capture_ir;
		logic shift_ir;
		logic update_ir;
		logic capture_dr;
		logic shift_dr;
		logic update_dr;
	} tap_state_t;

	// Decoded view of one instruction
	typedef struct packed {
		logic is_bsr;
		logic is_id;
		logic capture_pins;
		logic extest;
		logic highz;
	} ir_dec_t;
endpackage

`timescale 1ns/1ns
module sync2 #(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// First stage is read only by the second
	always_comb begin
		meta_nxt = rstn_i ? d_i : '0;
		q_nxt = rstn_i ? meta_r : '0;
	end

	always_ff @(posedge clock_i) begin
		meta_r <= meta_nxt;
		q_o <= q_nxt;
	end
endmodule

/* scan_ctrl_model.sv */
// Board-side scan controller model: makes the test clock and walks the port states
`timescale 1ns/1ns
module scan_ctrl_model
	import tap_decode_pkg::*;
(
	output logic tck_o,
	output tap_state_t tap_o,
	output logic tdi_o,
	input wire logic tdo_i
);
	localparam tap_state_t RST = 7'h40;
	localparam tap_state_t CAP_IR = 7'h20;
	localparam tap_state_t SH_IR = 7'h10;
	localparam tap_state_t UP_IR = 7'h08;
	localparam tap_state_t CAP_DR = 7'h04;
	localparam tap_state_t SH_DR = 7'h02;
	localparam tap_state_t UP_DR = 7'h01;

	// Test clock runs free, 160 ns period
	initial tck_o = 1'b0;
	always #80 tck_o = ~tck_o;
	initial begin
		tap_o = '0;
		tdi_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// One state for one tck; strobes change just after the edge, tdo read after it
	task automatic step(input tap_state_t s, input logic d, output logic q);
		tap_o <= s;
		tdi_o <= d;
		@(posedge tck_o);
		#1 q = tdo_i;
	endtask

	// Idle: serial input flips so a stale level never looks valid
	task automatic idle();
		tap_o <= '0;
		tdi_o <= ~tdi_o;
		@(posedge tck_o);
		#1;
	endtask

	task automatic tlr();
		logic q;
		step(RST, 1'b0, q);
		idle();
	endtask

	// Capture, three shifts, update; returns what the capture loaded
	task automatic load_ir(input logic [IR_W-1:0] code, output logic [IR_W-1:0] cap);
		logic q;
		step(CAP_IR, 1'b0, q);
		for (int i = 0; i < IR_W; i++) begin
			step(SH_IR, code[i], q);
			cap[i] = q;
		end
		step(UP_IR, 1'b0, q);
		idle();
	endtask

	// Capture, n shifts, update; bit 0 in and out first
	task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		step(CAP_DR, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(SH_DR, din[i], q);
			dout[i] = q;
		end
		step(UP_DR, 1'b0, q);
		idle();
	endtask
endmodule

/* tap_decode_tb.sv */
// Self-checking bench for the test-port instruction decoder
`timescale 1ns/1ns
module tap_decode_tb;
	import tap_decode_pkg::*;
	// Identity value is arbitrary
	localparam logic [ID_W-1:0] ID_T = 32'h5a3c_0f96;
	localparam int BW = 8;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [BW-1:0] pins_i = '0;
	logic tck, tdi, tdo, tdo_oe, extest, highz;
	tap_state_t tap;
	logic [BW-1:0] drive;
	logic [31:0] got;
	int n_mismatch = 0;
	int samples_checked = 0;
	int oe_cycles = 0;

	always #4 clock_i = ~clock_i;

	// Enable counted mid-cycle, well away from the tck edge that launches it
	always @(negedge tck) begin
		if (tdo_oe === 1'b1) begin
			oe_cycles++;
		end
	end

	scan_ctrl_model i_ctrl (.tck_o(tck), .tap_o(tap), .tdi_o(tdi), .tdo_i(tdo));
	tap_decode #(.BSR_W(BW), .ID_VALUE(ID_T)) i_dut (.clock_i(clock_i), .rstn_i(rstn_i),
		.tck_i(tck), .tap_i(tap), .tdi_i(tdi), .pins_i(pins_i), .tdo_o(tdo),
		.tdo_oe_o(tdo_oe), .bsr_drive_o(drive), .extest_o(extest), .highz_o(highz));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Load a code; capture must read back 001 first
	task automatic ir(input logic [IR_W-1:0] code);
		logic [IR_W-1:0] cap;
		i_ctrl.load_ir(code, cap);
		check("ir_capture", 32'(IR_CAPTURE_FULL), 32'(cap));
	endtask

	// Memory-side levels need a few clock cycles to cross
	task automatic mem_side(input logic ex, input logic hz);
		repeat (8) @(posedge clock_i);
		// Read after the edge's own update, never in its time step
		#1;
		check("extest", 32'(ex), 32'(extest));
		check("highz", 32'(hz), 32'(highz));
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_bypass_like();
		logic [IR_W-1:0] codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
		int oe_start;
		foreach (codes[k]) begin
			oe_start = oe_cycles;
			ir(codes[k]);
			i_ctrl.scan_dr(3, 32'h0000_0005, got);
			check("bypass_path", 32'h0000_0002, got);
			// One enabled cycle per shifted bit: three for the code, three for data
			check("tdo_oe_cycles", 32'h0000_0006, 32'(oe_cycles - oe_start));
		end
		// Identity reached by an explicit load, not only by reset
		ir(OP_IDCODE);
		t_id("id_loaded");
		mem_side(1'b0, 1'b0);
	endtask

	task automatic t_sample();
		@(posedge clock_i) pins_i <= 8'ha5;
		ir(OP_SAMPLE);
		i_ctrl.scan_dr(BW, 32'h0000_003c, got);
		check("sample_capture", 32'h0000_00a5, got);
		check("preload", 32'h0000_003c, 32'(drive));
		mem_side(1'b0, 1'b0);
	endtask

	task automatic t_extest();
		ir(OP_EXTEST);
		mem_side(1'b1, 1'b0);
		check("extest_drive", 32'h0000_003c, 32'(drive));
		i_ctrl.scan_dr(BW, 32'h0000_0081, got);
		check("extest_capture", 32'h0000_00a5, got);
		check("extest_update", 32'h0000_0081, 32'(drive));
	endtask

	task automatic t_highz();
		@(posedge clock_i) pins_i <= 8'h5a;
		ir(OP_SAMPLE_Z);
		mem_side(1'b0, 1'b1);
		i_ctrl.scan_dr(BW, 32'h0000_0000, got);
		check("highz_capture", 32'h0000_005a, got);
	endtask

	task automatic t_id(input string what);
		i_ctrl.scan_dr(ID_W, 32'h0000_0000, got);
		check(what, ID_T, got);
	endtask

	task automatic t_test_reset();
		i_ctrl.tlr();
		mem_side(1'b0, 1'b0);
		t_id("id_after_tlr");
	endtask

	// Hang guard: far beyond the whole sequence, still inside the cycle budget
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		// Reset must reach the tck side through its synchroniser
		repeat (4) @(posedge tck);
		@(posedge clock_i) rstn_i <= 1'b1;
		repeat (4) @(posedge tck);
		t_id("id_default");
		t_bypass_like();
		t_sample();
		t_extest();
		t_highz();
		t_test_reset();
		report_and_stop();
	end
endmodule
